// file: rtl/svd_bit_fifo.sv
// file: one gapped-clock bit fifo used on both directions
module svd_bit_fifo
    import svd_pkg::*;
#(
    parameter int DEPTH = SVD_DEPTH_MAX,
    parameter int FLOAT_STEPS = 0
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wr_valid_i,
    input wire svd_bit_t wr_data_i,
    input wire logic rd_tick_i,
    input wire logic [5:0] limit_i,
    output logic rd_valid_o,
    output svd_bit_t rd_data_o,
    output logic overflow_o,
    output logic [6:0] fill_o
);
    localparam int SIZE = DEPTH + FLOAT_STEPS * SVD_FLOAT_STEP_BITS;
    localparam int AW = $clog2(SIZE);
    svd_bit_t mem [SIZE];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [6:0] count;
    logic [6:0] limit_ext;
    logic full;
    logic do_wr;
    logic do_rd;

    // effective depth is the selected mode's depth plus float slack
    assign limit_ext = 7'(limit_i) + 7'(FLOAT_STEPS * SVD_FLOAT_STEP_BITS);  // see R8
    assign full = (count >= limit_ext);
    assign do_rd = rd_tick_i && (count != 7'h00);  // see R3
    // a read in the same cycle frees room, so a full fifo still takes the bit
    assign do_wr = wr_valid_i && (!full || do_rd);  // see R1 see R13
    assign fill_o = count;

    always_ff @(posedge clock_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;  // see R12
        end else if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(SIZE - 1)) ? '0 : wr_ptr + AW'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_ptr <= '0;  // see R12
            rd_valid_o <= 1'b0;
            rd_data_o <= '0;
        end else begin
            rd_valid_o <= do_rd;  // see R4
            if (do_rd) begin
                rd_data_o <= mem[rd_ptr];
                rd_ptr <= (rd_ptr == AW'(SIZE - 1)) ? '0 : rd_ptr + AW'(1);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count <= '0;  // see R12
        end else if (do_wr && !do_rd) begin
            count <= count + 7'h01;
        end else if (do_rd && !do_wr) begin
            count <= count - 7'h01;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            overflow_o <= 1'b0;
        end else if (wr_valid_i && !do_wr) begin
            overflow_o <= 1'b1;  // see R13
        end
    end
endmodule : svd_bit_fifo

// file: rtl/svd_desync.sv
// file: top of the sonet vt desynchronizing fifo, transmit and receive
// How it works
// R1: write only when demapper marks bit present
// R2: read pace is integer division, just above target
// R3: read tick removes a bit only if nonempty
// R4: output clock pulses only on real reads
// R5: divider 32 or 33 for t1, 25 e1
// R6: depth 21, 26 or 34 per divider
// R7: divider and depth bound output gap to 12
// R8: add 8 depth bits per pointer move
// R9: absorb input gaps of 24 or 32 bits
// R10: receive buffer of same depth as transmit
// R11: data stable around gapped clock falling edge
// R12: reset clears pointers and fill, clock idle
// R13: full fifo drops writes unless a read in the same cycle frees room, sticky overflow flag
module svd_desync
    import svd_pkg::*;
#(
    parameter int FLOAT_STEPS = 0
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire svd_rate_t rate_sel_i,
    input wire logic tx_bit_present_i,
    input wire svd_bit_t tx_bit_i,
    output logic transmit_line_clock_o,
    output logic transmit_positive_data_o,
    output logic transmit_negative_data_o,
    output logic tx_overflow_o,
    input wire logic rx_bit_valid_i,
    input wire svd_bit_t rx_bit_i,
    input wire logic rx_slot_i,
    output logic rx_bit_valid_o,
    output svd_bit_t rx_bit_o,
    output logic rx_overflow_o
);
    logic [5:0] div_value;
    logic [5:0] depth_value;
    logic [5:0] div_count;
    logic [5:0] half_count;
    logic rd_tick;
    logic tx_rd_valid;
    svd_bit_t tx_rd_data;
    logic clk_high;

    // divider and depth pairs keep the worst output gap at 12 bits or less
    always_comb begin
        unique case (rate_sel_i)
            SVD_RATE_T1_SLOW: begin
                div_value = SVD_DIV_T1_SLOW;  // see R5 see R7
                depth_value = 6'(SVD_DEPTH_T1_SLOW);  // see R6
            end
            SVD_RATE_E1: begin
                div_value = SVD_DIV_E1;  // see R5 see R7
                depth_value = 6'(SVD_DEPTH_E1);  // see R6
            end
            default: begin
                div_value = SVD_DIV_T1_FAST;  // see R5 see R7
                depth_value = 6'(SVD_DEPTH_T1_FAST);  // see R6
            end
        endcase
    end

    // integer division of the 51.84 MHz clock gives the read pace
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            div_count <= '0;
        end else if (div_count >= div_value - 6'h01) begin
            div_count <= '0;  // see R2
        end else begin
            div_count <= div_count + 6'h01;
        end
    end
    assign rd_tick = (div_count >= div_value - 6'h01);  // see R2

    // depth covers input bursts spaced up to 24 t1 or 32 e1 bit times
    svd_bit_fifo #(
        .DEPTH(SVD_DEPTH_MAX),
        .FLOAT_STEPS(FLOAT_STEPS)
    ) u_tx_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .wr_valid_i(tx_bit_present_i),  // see R1 see R9
        .wr_data_i(tx_bit_i),
        .rd_tick_i(rd_tick),
        .limit_i(depth_value),
        .rd_valid_o(tx_rd_valid),
        .rd_data_o(tx_rd_data),
        .overflow_o(tx_overflow_o),
        .fill_o()
    );

    // clock rises with new data and falls mid-period, so data is settled
    // a half period either side of the falling edge
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clk_high <= 1'b0;  // see R12
            half_count <= '0;
        end else if (tx_rd_valid) begin
            clk_high <= 1'b1;  // see R4
            half_count <= '0;
        end else if (clk_high && half_count >= (div_value >> 1) - 6'h01) begin
            clk_high <= 1'b0;  // see R11
        end else begin
            half_count <= half_count + 6'h01;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            transmit_positive_data_o <= 1'b0;
            transmit_negative_data_o <= 1'b0;
        end else if (tx_rd_valid) begin
            transmit_positive_data_o <= tx_rd_data.pos;  // see R11
            transmit_negative_data_o <= tx_rd_data.neg;
        end
    end
    assign transmit_line_clock_o = clk_high;

    // receive side: same depth, drained in the sonet payload slots
    svd_bit_fifo #(
        .DEPTH(SVD_DEPTH_MAX),
        .FLOAT_STEPS(FLOAT_STEPS)
    ) u_rx_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .wr_valid_i(rx_bit_valid_i),
        .wr_data_i(rx_bit_i),
        .rd_tick_i(rx_slot_i),
        .limit_i(depth_value),  // see R10
        .rd_valid_o(rx_bit_valid_o),
        .rd_data_o(rx_bit_o),
        .overflow_o(rx_overflow_o),
        .fill_o()
    );
endmodule : svd_desync

// file: rtl/svd_pkg.sv
// package: constants and carrier types for the vt desync fifo
package svd_pkg;
    localparam int SVD_SYS_CLK_KHZ = 51840;
    localparam int SVD_T1_TARGET_KHZ = 1544;
    localparam int SVD_E1_TARGET_KHZ = 2048;
    localparam int SVD_DIV_W = 6;
    localparam logic [5:0] SVD_DIV_T1_FAST = 6'h20;
    localparam logic [5:0] SVD_DIV_T1_SLOW = 6'h21;
    localparam logic [5:0] SVD_DIV_E1 = 6'h19;
    localparam int SVD_DEPTH_T1_FAST = 21;
    localparam int SVD_DEPTH_T1_SLOW = 26;
    localparam int SVD_DEPTH_E1 = 34;
    localparam int SVD_MAX_GAP_BITS = 12;
    localparam int SVD_FLOAT_STEP_BITS = 8;
    localparam int SVD_T1_MAX_IN_GAP = 24;
    localparam int SVD_E1_MAX_IN_GAP = 32;
    localparam int SVD_T1_FRAME_BITS = 193;
    localparam int SVD_E1_FRAME_BITS = 256;
    localparam int SVD_SONET_FRAME_BITS = 6480;
    localparam int SVD_DEPTH_MAX = 34;
    typedef enum logic [1:0] {
        SVD_RATE_T1_FAST = 2'b00,
        SVD_RATE_T1_SLOW = 2'b01,
        SVD_RATE_E1 = 2'b10
    } svd_rate_t;
    // one line-side bit pair: positive and negative rail
    typedef struct packed {
        logic pos;
        logic neg;
    } svd_bit_t;
endpackage : svd_pkg

// file: tb/svd_desync_sva.sv
// checker: port assertions of the vt desync fifo
module svd_desync_sva
    import svd_pkg::*;
#(
    parameter int FLOAT_STEPS = 0
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire svd_rate_t rate_sel_i,
    input wire logic tx_bit_present_i,
    input wire logic transmit_line_clock_o,
    input wire logic transmit_positive_data_o,
    input wire logic transmit_negative_data_o,
    input wire logic tx_overflow_o,
    input wire logic rx_slot_i,
    input wire logic rx_bit_valid_o,
    input wire logic rx_overflow_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] dv;
    logic [6:0] hi;
    logic [6:0] gap;
    assign dv = {1'b0, rate_sel_i == SVD_RATE_E1 ? SVD_DIV_E1 :
        rate_sel_i == SVD_RATE_T1_SLOW ? SVD_DIV_T1_SLOW : SVD_DIV_T1_FAST};
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) hi <= 7'h00;
        else hi <= transmit_line_clock_o ? hi + 7'h01 : 7'h00;
    end
    // saturates so a long idle never wraps into a false multiple
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) gap <= 7'h7F;
        else if ($rose(transmit_line_clock_o)) gap <= 7'h01;
        else if (gap != 7'h7F) gap <= gap + 7'h01;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_release;
        !rst_n_i ##1 rst_n_i;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0)
        s_release |-> !transmit_line_clock_o && !tx_overflow_o && !rx_overflow_o)
        else $error("outputs not idle after reset");
    a_high_len: assert property (
        $fell(transmit_line_clock_o) |-> hi == (dv >> 1)) else $error("clock high width");
    a_tick_spacing: assert property (
        $rose(transmit_line_clock_o) |-> gap >= dv && (gap == 7'h7F || gap % dv == 7'h00))
        else $error("read tick spacing");
    a_data_stable: assert property (
        !$rose(transmit_line_clock_o) |->
        $stable({transmit_positive_data_o, transmit_negative_data_o})) else $error("data moved");
    a_ovf_sticky: assert property (tx_overflow_o |=> tx_overflow_o)
        else $error("tx overflow dropped");
    a_ovf_cause: assert property ($rose(tx_overflow_o) |-> $past(tx_bit_present_i))
        else $error("overflow without write");
    a_rx_answer: assert property (rx_bit_valid_o |-> $past(rx_slot_i))
        else $error("rx valid without slot");
    a_rx_sticky: assert property (rx_overflow_o |=> rx_overflow_o)
        else $error("rx overflow dropped");
endmodule : svd_desync_sva
bind svd_desync svd_desync_sva #(.FLOAT_STEPS(FLOAT_STEPS)) i_svd_desync_sva (.clock_i,
    .rst_n_i, .rate_sel_i, .tx_bit_present_i, .transmit_line_clock_o, .transmit_positive_data_o,
    .transmit_negative_data_o, .tx_overflow_o, .rx_slot_i, .rx_bit_valid_o, .rx_overflow_o);

// file: tb/svd_desync_tb.sv
// testbench: random and corner traffic through the vt desync fifo
module svd_desync_tb
    import svd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, pres, rxv, slot, lclk, lpos, lneg, tovf, rxvo, rxovf;
    svd_rate_t rate;
    svd_bit_t txb, rxb, rxbo;
    svd_bit_t exp[$];
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int d, n;
    // one float step of slack, so the added depth is exercised as well
    localparam int FLT = 1;
    svd_desync #(.FLOAT_STEPS(FLT)) i_svd_desync (.clock_i(clk), .rst_n_i(rst_n),
        .rate_sel_i(rate), .tx_bit_present_i(pres), .tx_bit_i(txb),
        .transmit_line_clock_o(lclk), .transmit_positive_data_o(lpos),
        .transmit_negative_data_o(lneg), .tx_overflow_o(tovf), .rx_bit_valid_i(rxv),
        .rx_bit_i(rxb), .rx_slot_i(slot), .rx_bit_valid_o(rxvo), .rx_bit_o(rxbo),
        .rx_overflow_o(rxovf));
    svd_line_model i_svd_line_model (.line_clk_i(lclk), .pos_i(lpos), .neg_i(lneg));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    function automatic int dep(svd_rate_t r);
        return r == SVD_RATE_E1 ? SVD_DEPTH_E1 : r == SVD_RATE_T1_SLOW ? SVD_DEPTH_T1_SLOW
            : SVD_DEPTH_T1_FAST;
    endfunction : dep
    // same bit to both directions; odd random idle cycles mimic mapping gaps
    task automatic put(input int k);
        for (int i = 0; i < k; i++) begin
            if ($urandom % 4 == 0) begin
                pres = 1'b0;
                rxv = 1'b0;
                @(posedge clk);
                #1;
            end
            txb = svd_bit_t'(2'($urandom));
            rxb = txb;
            exp.push_back(txb);
            pres = 1'b1;
            rxv = 1'b1;
            @(posedge clk);
            #1;
        end
        pres = 1'b0;
        rxv = 1'b0;
    endtask : put
    task automatic drain;
        for (int k = 0; k < 3000 && i_svd_line_model.got.size() < d; k++) @(posedge clk);
        #1;
        check(8'(i_svd_line_model.got.size() >= d), 8'h01);
        for (int i = 0; i < d; i++) check(8'(i_svd_line_model.got[i]), 8'(exp[i]));
    endtask : drain
    // one slot every other cycle; the last slot finds the buffer empty and data standing
    task automatic rx_pull;
        for (int i = 0; i <= d; i++) begin
            slot = 1'b1;
            @(posedge clk);
            #1;
            slot = 1'b0;
            check({5'h00, rxvo, rxbo}, {6'(i < d), i < d ? exp[i] : exp[d - 1]});
            @(posedge clk);
            #1;
        end
    endtask : rx_pull
    initial begin
        void'($urandom(32'h8d884628));
        {rst_n, pres, rxv, slot, txb, rxb} = 8'h00;
        rate = SVD_RATE_T1_FAST;
        for (int r = 0; r < 4; r++) begin
            rst_n = 1'b0;
            rate = svd_rate_t'(r);
            d = dep(rate) + FLT * SVD_FLOAT_STEP_BITS;
            repeat (12) @(posedge clk);
            #1;
            rst_n = 1'b1;
            check({2'b00, lclk, lpos, lneg, tovf, rxvo, rxovf}, 8'h00);
            exp.delete();
            i_svd_line_model.got.delete();
            put(d);
            check({6'h00, tovf, rxovf}, 8'h00);
            drain();
            rx_pull();
            exp.delete();
            i_svd_line_model.got.delete();
            put(2 * d);
            check({6'h00, tovf, rxovf}, 8'h03);
            drain();
            // only the first bits fit while no slot drains the receive side
            rx_pull();
            repeat (200) @(posedge clk);
            n = i_svd_line_model.got.size();
            repeat (300) @(posedge clk);
            #1;
            check(8'(i_svd_line_model.got.size() - n), 8'h00);
        end
        close_out();
    end
endmodule : svd_desync_tb

// file: tb/svd_line_model.sv
// partner: line side taking bits on the gapped clock fall
module svd_line_model
    import svd_pkg::*;
(
    input wire logic line_clk_i,
    input wire logic pos_i,
    input wire logic neg_i
);
    timeunit 1ns;
    timeprecision 1ps;
    svd_bit_t got[$];
    always @(negedge line_clk_i) got.push_back('{pos: pos_i, neg: neg_i});
endmodule : svd_line_model
